// ---- hdl/spcm_console_mgr.sv ----
/*
 Serial path console manager: path routing, entry detection, stored strings,
 session control, idle logout and modem command streaming.
 Assumes inputs synchronous to core_clk and a firmware console on fwMode*.
*/
`timescale 1ns/1ns
module spcm_console_mgr
    import spcm_pkg::*;
#(
    parameter int CYC_PER_MIN = CYC_PER_MIN_DEF
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire spcm_char_type hostIn,
    output logic hostReady,
    output spcm_char_type modemOut,
    input wire logic modemReady,
    output logic bypassRoute,
    output logic remoteMgmtEn,
    input wire logic fwModeWr,
    input wire spcm_mode_type fwModeVal,
    output spcm_mode_type serialPathMode,
    input wire logic hostPowerOn,
    input wire logic alertIn,
    input wire logic carrierDetect,
    input wire logic modemRxActive,
    input wire logic localEntryReq,
    input wire logic sessionQuit,
    output logic sessActive,
    output logic sessRemote,
    output logic hangupPulse,
    input wire spcm_cfg_type cfgIn,
    output spcm_char_type echoOut,
    output logic passSet,
    output logic passErr,
    input wire logic enableRemote,
    input wire logic hostFlowSetting,
    output logic modemFlowCfg,
    output logic modemCdEn,
    output spcm_char_type modemCmd,
    input wire logic modemCmdReady,
    input wire logic [5:0] userRdIdx,
    output logic [7:0] userRdChar,
    output logic [5:0] userLen,
    output logic [3:0] logoutTens
);
    function automatic logic [7:0] toUpper(input logic [7:0] c);
        return (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
    endfunction

    function automatic logic [5:0] strMax(input spcm_sel_type s);
        unique case (s)
            SEL_ESC, SEL_PASS, SEL_VERIFY: return 6'(ESC_MAX);
            SEL_DIAL: return 6'(DIAL_MAX);
            SEL_INIT: return 6'(INIT_MAX);
            SEL_ALERT: return 6'(ALERT_MAX);
            SEL_USER: return 6'(USER_MAX);
            SEL_LOGOUT: return 6'h01;
        endcase
    endfunction

    spcm_mode_type mode_reg, mode_next;
    logic carrier_reg, alert_reg;
    logic sessActive_reg, sessActive_next, sessRemote_reg, sessRemote_next;
    logic [7:0] escArr[ESC_MAX], dialArr[DIAL_MAX], alertArr[ALERT_MAX];
    logic [7:0] initArr[INIT_MAX], passArr[PASS_MAX], userArr[USER_MAX];
    logic [5:0] wrIdx_reg, wrIdx_next, escLen_reg, escLen_next, dialLen_reg, dialLen_next;
    logic [5:0] alertLen_reg, alertLen_next, initLen_reg, initLen_next;
    logic [5:0] passLen_reg, passLen_next, userLen_reg, userLen_next;
    logic mism_reg, mism_next, passSet_reg, passSet_next, passErr_reg, passErr_next;
    logic [3:0] logout_reg, logout_next;
    spcm_char_type echo_reg, echo_next;
    logic [7:0] cfgCh;
    logic fits, mismNow;
    logic [5:0] cnt;
    logic [3:0] match_reg, match_next;
    logic obs, escHit, remoteOk, carrierFall, alertRise;
    logic [31:0] cyc_reg, cyc_next;
    logic [6:0] min_reg, min_next, minLimit;
    logic timeout, hangup_reg;
    logic [1:0] bufCnt_reg, bufCnt_next;
    logic [7:0] buf0_reg, buf0_next, buf1_reg, buf1_next;
    logic push, pop;
    spcm_cmd_type cmd_reg, cmd_next;
    logic [5:0] cmdIdx_reg, cmdIdx_next, cmdLen;
    logic flow_reg, flow_next, cdEn_reg, cdEn_next;

    assign carrierFall = carrier_reg && !carrierDetect;
    assign alertRise = alertIn && !alert_reg;

    // Path mode
    always_comb begin
        mode_next = mode_reg;
        if (fwModeWr) begin
            mode_next = fwModeVal;
        end else if (mode_reg == MODE_SOFT && (alertIn || carrierFall)) begin
            mode_next = MODE_SNOOP;
        end else if (mode_reg == MODE_SOFT && !hostPowerOn) begin
            mode_next = MODE_SNOOP;
        end
    end

    // Session: one at a time; local entry accepted in every mode while no session is active
    always_comb begin
        sessActive_next = sessActive_reg;
        sessRemote_next = sessRemote_reg;
        if (sessActive_reg) begin
            if (sessionQuit || timeout || (sessRemote_reg &&
                    (carrierFall || mode_reg == MODE_FIRM))) begin
                sessActive_next = 1'b0;
                sessRemote_next = 1'b0;
            end
        end else if (localEntryReq) begin
            sessActive_next = 1'b1;
        end else if (escHit && remoteOk) begin
            sessActive_next = 1'b1;
            sessRemote_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mode_reg <= MODE_THROUGH;
            carrier_reg <= 1'b0;
            alert_reg <= 1'b0;
            sessActive_reg <= 1'b0;
            sessRemote_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            carrier_reg <= carrierDetect;
            alert_reg <= alertIn;
            sessActive_reg <= sessActive_next;
            sessRemote_reg <= sessRemote_next;
        end
    end

    // Entry sequence scan; in tap mode every character is seen, never stalled
    assign obs = (mode_reg == MODE_THROUGH) ? push :
        (mode_reg == MODE_SNOOP) && hostIn.valid;
    assign escHit = obs && escLen_reg != 6'h00 && hostIn.data == escArr[match_reg] &&
        6'(match_reg) + 6'h01 == escLen_reg;
    // Soft and firm bypass refuse remote entry; a password must exist
    assign remoteOk = passSet_reg && !sessActive_reg &&
        (mode_reg == MODE_THROUGH || mode_reg == MODE_SNOOP);

    always_comb begin
        match_next = match_reg;
        if (escLen_reg == 6'h00 || escHit) begin
            match_next = 4'h0;
        end else if (obs) begin
            match_next = (hostIn.data == escArr[match_reg]) ? match_reg + 4'h1 : 4'h0;
        end
    end

    // Configuration strings
    assign cfgCh = (cfgIn.sel == SEL_DIAL || cfgIn.sel == SEL_INIT) ?
        toUpper(cfgIn.ch) : cfgIn.ch;
    assign fits = wrIdx_reg < strMax(cfgIn.sel);
    assign cnt = fits ? wrIdx_reg + 6'h01 : wrIdx_reg;
    assign mismNow = mism_reg || wrIdx_reg >= passLen_reg ||
        passArr[wrIdx_reg[3:0]] != cfgIn.ch;

    always_comb begin
        wrIdx_next = wrIdx_reg;
        escLen_next = escLen_reg;
        dialLen_next = dialLen_reg;
        alertLen_next = alertLen_reg;
        initLen_next = initLen_reg;
        passLen_next = passLen_reg;
        userLen_next = userLen_reg;
        mism_next = mism_reg;
        passSet_next = passSet_reg;
        passErr_next = 1'b0;
        logout_next = logout_reg;
        // No echo while a password is typed
        echo_next.valid = cfgIn.wr && cfgIn.sel != SEL_PASS && cfgIn.sel != SEL_VERIFY;
        echo_next.data = cfgCh;
        if (cfgIn.wr) begin
            wrIdx_next = cfgIn.last ? 6'h00 : cnt;
            if (cfgIn.sel == SEL_ESC && wrIdx_reg == 6'h00) begin
                escLen_next = 6'h00;
            end
            if (cfgIn.sel == SEL_VERIFY) begin
                mism_next = mismNow;
            end
            if (cfgIn.last) begin
                mism_next = 1'b0;
                unique case (cfgIn.sel)
                    SEL_ESC: escLen_next = cnt;
                    SEL_DIAL: dialLen_next = cnt;
                    SEL_ALERT: alertLen_next = cnt;
                    SEL_INIT: initLen_next = cnt;
                    SEL_USER: userLen_next = cnt;
                    SEL_PASS: begin
                        passLen_next = cnt;
                        passSet_next = 1'b0;
                    end
                    SEL_VERIFY: begin
                        passSet_next = !mismNow && cnt == passLen_reg;
                        passErr_next = mismNow || cnt != passLen_reg;
                    end
                    SEL_LOGOUT: begin
                        if (cfgIn.ch >= 8'h30 && cfgIn.ch <= 8'h39) begin
                            logout_next = cfgIn.ch[3:0];
                        end
                    end
                endcase
            end
        end
    end

    // Arrays are plain storage; chars past the limit are dropped
    always_ff @(posedge core_clk) begin
        if (cfgIn.wr && fits) begin
            unique case (cfgIn.sel)
                SEL_ESC: escArr[wrIdx_reg[3:0]] <= cfgCh;
                SEL_DIAL: dialArr[wrIdx_reg[4:0]] <= cfgCh;
                SEL_ALERT: alertArr[wrIdx_reg[4:0]] <= cfgCh;
                SEL_INIT: initArr[wrIdx_reg[4:0]] <= cfgCh;
                SEL_PASS: passArr[wrIdx_reg[3:0]] <= cfgCh;
                SEL_USER: userArr[wrIdx_reg] <= cfgCh;
                SEL_VERIFY, SEL_LOGOUT: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            wrIdx_reg <= 6'h00;
            escLen_reg <= 6'h00;
            dialLen_reg <= 6'h00;
            alertLen_reg <= 6'h00;
            initLen_reg <= 6'h00;
            passLen_reg <= 6'h00;
            userLen_reg <= 6'h00;
            mism_reg <= 1'b0;
            passSet_reg <= 1'b0;
            passErr_reg <= 1'b0;
            logout_reg <= LOGOUT_RST;
            echo_reg <= '0;
            match_reg <= 4'h0;
        end else begin
            wrIdx_reg <= wrIdx_next;
            escLen_reg <= escLen_next;
            dialLen_reg <= dialLen_next;
            alertLen_reg <= alertLen_next;
            initLen_reg <= initLen_next;
            passLen_reg <= passLen_next;
            userLen_reg <= userLen_next;
            mism_reg <= mism_next;
            passSet_reg <= passSet_next;
            passErr_reg <= passErr_next;
            logout_reg <= logout_next;
            echo_reg <= echo_next;
            match_reg <= match_next;
        end
    end

    // Idle logout: minute prescaler then a minute count; zero setting never fires
    assign minLimit = 7'(logout_reg) * MIN_PER_TENS;
    assign timeout = sessRemote_reg && logout_reg != 4'h0 && min_reg == minLimit;

    always_comb begin
        cyc_next = cyc_reg + 32'h1;
        min_next = min_reg;
        if (!sessRemote_reg || modemRxActive) begin
            cyc_next = 32'h0;
            min_next = 7'h00;
        end else if (cyc_reg == 32'(CYC_PER_MIN - 1)) begin
            cyc_next = 32'h0;
            if (min_reg != minLimit) begin
                min_next = min_reg + 7'h01;
            end
        end
    end

    // Two-entry buffer on the pass-through path; a modem stall backs up to the host
    assign push = hostIn.valid && hostReady && mode_reg == MODE_THROUGH;
    assign pop = modemOut.valid && modemReady;

    always_comb begin
        bufCnt_next = bufCnt_reg + 2'(push) - 2'(pop);
        buf0_next = buf0_reg;
        buf1_next = buf1_reg;
        if (pop) begin
            buf0_next = buf1_reg;
        end
        if (push) begin
            if (bufCnt_reg - 2'(pop) == 2'h0) begin
                buf0_next = hostIn.data;
            end else begin
                buf1_next = hostIn.data;
            end
        end
    end

    // Modem command stream: init on enable, dial then alert on an alert
    always_comb begin
        cmd_next = cmd_reg;
        cmdIdx_next = cmdIdx_reg;
        flow_next = flow_reg;
        cdEn_next = cdEn_reg;
        unique case (cmd_reg)
            CMD_IDLE: begin
                if (enableRemote && passSet_reg && initLen_reg != 6'h00 &&
                        mode_reg != MODE_FIRM) begin
                    cmd_next = CMD_INIT;
                    flow_next = hostFlowSetting;
                    cdEn_next = 1'b1;
                end else if (alertRise && mode_reg != MODE_FIRM && !sessActive_reg &&
                        dialLen_reg != 6'h00) begin
                    cmd_next = CMD_DIAL;
                end
            end
            CMD_INIT, CMD_DIAL, CMD_ALERT: begin
                if (modemCmdReady) begin
                    cmdIdx_next = cmdIdx_reg + 6'h01;
                    if (cmdIdx_next == cmdLen) begin
                        cmdIdx_next = 6'h00;
                        cmd_next = (cmd_reg == CMD_DIAL && alertLen_reg != 6'h00) ?
                            CMD_ALERT : CMD_IDLE;
                    end
                end
            end
        endcase
    end

    always_comb begin
        cmdLen = initLen_reg;
        modemCmd.data = initArr[cmdIdx_reg[4:0]];
        if (cmd_reg == CMD_DIAL) begin
            cmdLen = dialLen_reg;
            modemCmd.data = dialArr[cmdIdx_reg[4:0]];
        end else if (cmd_reg == CMD_ALERT) begin
            cmdLen = alertLen_reg;
            modemCmd.data = alertArr[cmdIdx_reg[4:0]];
        end
        modemCmd.valid = cmd_reg != CMD_IDLE;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cyc_reg <= 32'h0;
            min_reg <= 7'h00;
            hangup_reg <= 1'b0;
            bufCnt_reg <= 2'h0;
            buf0_reg <= 8'h00;
            buf1_reg <= 8'h00;
            cmd_reg <= CMD_IDLE;
            cmdIdx_reg <= 6'h00;
            flow_reg <= 1'b0;
            cdEn_reg <= 1'b0;
        end else begin
            cyc_reg <= cyc_next;
            min_reg <= min_next;
            hangup_reg <= timeout;
            bufCnt_reg <= bufCnt_next;
            buf0_reg <= buf0_next;
            buf1_reg <= buf1_next;
            cmd_reg <= cmd_next;
            cmdIdx_reg <= cmdIdx_next;
            flow_reg <= flow_next;
            cdEn_reg <= cdEn_next;
        end
    end

    assign hostReady = (mode_reg == MODE_THROUGH) ? bufCnt_reg != 2'h2 : 1'b1;
    assign modemOut.valid = bufCnt_reg != 2'h0;
    assign modemOut.data = buf0_reg;
    assign bypassRoute = mode_reg != MODE_THROUGH;
    assign remoteMgmtEn = mode_reg != MODE_FIRM;
    assign serialPathMode = mode_reg;
    assign sessActive = sessActive_reg;
    assign sessRemote = sessRemote_reg;
    assign hangupPulse = hangup_reg;
    assign echoOut = echo_reg;
    assign passSet = passSet_reg;
    assign passErr = passErr_reg;
    assign modemFlowCfg = flow_reg;
    assign modemCdEn = cdEn_reg;
    assign userRdChar = (userRdIdx < userLen_reg) ? userArr[userRdIdx] : 8'h00;
    assign userLen = userLen_reg;
    assign logoutTens = logout_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_softAlert;
        mode_reg == MODE_SOFT && (alertIn || carrierFall) && !fwModeWr |=> mode_reg == MODE_SNOOP;
    endproperty
    a_softAlert: assert property (p_softAlert) else $error("no fall back to tap");
    property p_powerOff;
        mode_reg == MODE_SOFT && !hostPowerOn && !fwModeWr |=> mode_reg == MODE_SNOOP;
    endproperty
    a_powerOff: assert property (p_powerOff) else $error("power off kept soft bypass");
    property p_firmHold;
        mode_reg == MODE_FIRM && !fwModeWr |=> mode_reg == MODE_FIRM && !remoteMgmtEn;
    endproperty
    a_firmHold: assert property (p_firmHold) else $error("firm bypass not held");
    property p_local;
        localEntryReq && !sessActive_reg |=> sessActive_reg && !sessRemote_reg;
    endproperty
    a_local: assert property (p_local) else $error("local entry refused");
    property p_remoteNeedsPass;
        $rose(sessRemote_reg) |-> $past(passSet_reg) && $past(escHit) && !$past(sessActive_reg);
    endproperty
    a_remoteNeedsPass: assert property (p_remoteNeedsPass) else $error("bad entry");
    property p_verifyFail;
        cfgIn.wr && cfgIn.last && cfgIn.sel == SEL_VERIFY && mismNow |=>
            passErr_reg && !passSet_reg;
    endproperty
    a_verifyFail: assert property (p_verifyFail) else $error("mismatch not reported");
    property p_noEcho;
        cfgIn.wr && cfgIn.sel == SEL_PASS |=> !echo_reg.valid;
    endproperty
    a_noEcho: assert property (p_noEcho) else $error("password echoed");
    property p_noLogout;
        logout_reg == 4'h0 |=> !hangup_reg;
    endproperty
    a_noLogout: assert property (p_noLogout) else $error("logout fired while disabled");
    property p_through;
        mode_reg == MODE_THROUGH && bufCnt_reg == 2'h0 && hostIn.valid |=> modemOut.valid;
    endproperty
    a_through: assert property (p_through) else $error("through data lost");
    property p_dialThenAlert;
        cmd_reg == CMD_DIAL && cmd_next != CMD_DIAL && alertLen_reg != 6'h00 |=>
            cmd_reg == CMD_ALERT;
    endproperty
    a_dialThenAlert: assert property (p_dialThenAlert) else $error("no alert after dial");

    c_remote: cover property ($rose(sessRemote_reg));
    c_softSnoop: cover property (mode_reg == MODE_SOFT ##1 mode_reg == MODE_SNOOP);
    c_full: cover property (bufCnt_reg == 2'h2 && !modemReady);
    c_timeout: cover property (hangup_reg);
endmodule

// ---- pkg/spcm_pkg.sv ----
/*
 Shared types and constants of the serial path console manager.
 Assumes one 10 MHz core clock; strings arrive one character per cycle.
*/
package spcm_pkg;
    // Gray order along the usual fall-back path
    typedef enum logic [1:0] {
        MODE_THROUGH = 2'b00,
        MODE_SNOOP = 2'b01,
        MODE_SOFT = 2'b11,
        MODE_FIRM = 2'b10
    } spcm_mode_type;

    typedef enum logic [2:0] {
        SEL_ESC = 3'h0,
        SEL_DIAL = 3'h1,
        SEL_INIT = 3'h2,
        SEL_PASS = 3'h3,
        SEL_VERIFY = 3'h4,
        SEL_USER = 3'h5,
        SEL_ALERT = 3'h6,
        SEL_LOGOUT = 3'h7
    } spcm_sel_type;

    typedef enum logic [1:0] {
        CMD_IDLE = 2'b00,
        CMD_INIT = 2'b01,
        CMD_DIAL = 2'b11,
        CMD_ALERT = 2'b10
    } spcm_cmd_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } spcm_char_type;

    typedef struct packed {
        logic wr;
        spcm_sel_type sel;
        logic [7:0] ch;
        logic last;
    } spcm_cfg_type;

    localparam int ESC_MAX = 14;
    localparam int INIT_MAX = 31;
    localparam int PASS_MAX = 14;
    localparam int USER_MAX = 63;
    localparam int DIAL_MAX = 31;
    localparam int ALERT_MAX = 31;
    localparam logic [3:0] LOGOUT_RST = 4'h2;
    localparam logic [6:0] MIN_PER_TENS = 7'h0a;
    localparam int CLK_HZ = 10_000_000;
    localparam int SEC_PER_MIN = 60;
    localparam int CYC_PER_MIN_DEF = CLK_HZ * SEC_PER_MIN;
endpackage

// ---- verif/serial_path_console_manager_bench.sv ----
/*
 Bench of the console manager: random host stream, strings, entry, modes, logout.
 Assumes a modem model on the far side; minutes shrunk to 10 cycles.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module serial_path_console_manager_bench
    import spcm_pkg::*;
;
    localparam int CPM = 10;
    logic core_clk, nrst, slow, lineUp, fwModeWr, hostPowerOn, alertIn, modemRxActive;
    logic localEntryReq, sessionQuit, enableRemote, hostFlowSetting, hostReady, modemReady;
    logic bypassRoute, remoteMgmtEn, sessActive, sessRemote, hangupPulse, passSet, passErr;
    logic modemFlowCfg, modemCdEn, modemCmdReady, carrierDetect;
    spcm_char_type hostIn, modemOut, echoOut, modemCmd;
    spcm_mode_type fwModeVal, serialPathMode;
    spcm_cfg_type cfgIn;
    logic [5:0] userRdIdx, userLen;
    logic [7:0] userRdChar;
    logic [3:0] logoutTens;
    logic [31:0] rnd = 32'he05f;
    logic [7:0] sentQ[$], gotQ[$], cmdQ[$];
    int fails = 0, nCompared = 0, n;
    string initStr = "at&fe0v0x0s0=2abcdefghijklmnopqrs";
    spcm_console_mgr #(.CYC_PER_MIN(CPM)) uut (.core_clk, .nrst, .hostIn, .hostReady,
        .modemOut, .modemReady, .bypassRoute, .remoteMgmtEn, .fwModeWr, .fwModeVal,
        .serialPathMode, .hostPowerOn, .alertIn, .carrierDetect, .modemRxActive,
        .localEntryReq, .sessionQuit, .sessActive, .sessRemote, .hangupPulse, .cfgIn,
        .echoOut, .passSet, .passErr, .enableRemote, .hostFlowSetting, .modemFlowCfg,
        .modemCdEn, .modemCmd, .modemCmdReady, .userRdIdx, .userRdChar, .userLen, .logoutTens);
    spcm_modem_model model (.core_clk, .slow, .lineUp, .modemReady, .modemCmdReady,
        .carrierDetect);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (nrst && hostIn.valid && hostReady && !bypassRoute) sentQ.push_back(hostIn.data);
        if (nrst && modemOut.valid && modemReady) gotQ.push_back(modemOut.data);
        if (nrst && modemCmd.valid && modemCmdReady) cmdQ.push_back(modemCmd.data);
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] upc(input logic [7:0] c);
        return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
    endfunction
    task step(input int k = 1);
        // Valid drops only here, so back-to-back host calls keep it high between chars
        hostIn.valid = 1'b0;
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic cfg(input spcm_sel_type s, input string str);
        // Idle edge first: back-to-back strings never drive cfgIn twice at once
        step();
        for (int i = 0; i < str.len(); i++) begin
            cfgIn = '{1'b1, s, str[i], i == str.len() - 1};
            step();
            if (s inside {SEL_DIAL, SEL_INIT}) `CHK(echoOut, {1'b1, upc(str[i])})
            if (s inside {SEL_PASS, SEL_VERIFY}) `CHK(echoOut.valid, 1'b0)
        end
        cfgIn.wr = 1'b0;
    endtask
    task automatic host(input logic [7:0] d);
        hostIn = '{1'b1, d};
        do @(posedge core_clk); while (!hostReady);
        #1;
    endtask
    task escape();
        host(8'h1b);
        host(8'h1b);
        step(3);
    endtask
    task set_mode(input spcm_mode_type m);
        fwModeVal = m;
        fwModeWr = 1'b1;
        step();
        fwModeWr = 1'b0;
    endtask
    task pulse_local();
        localEntryReq = 1'b1;
        step();
        localEntryReq = 1'b0;
        step();
    endtask
    task quit();
        sessionQuit = 1'b1;
        step();
        sessionQuit = 1'b0;
        step();
    endtask
    task automatic expect_cmd(input string s, input int lim);
        step(120);
        `CHK(cmdQ.size(), lim)
        for (int i = 0; i < lim; i++) `CHK(cmdQ[i], upc(s[i]))
        cmdQ = {};
    endtask
    task complete_run();
        if (fails == 0 && nCompared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #(100 * 6000);
        fails++;
        complete_run();
    end
    initial begin
        nrst = 0; slow = 0; lineUp = 1; fwModeWr = 0; fwModeVal = MODE_THROUGH;
        hostPowerOn = 1; alertIn = 0; modemRxActive = 0; localEntryReq = 0; sessionQuit = 0;
        enableRemote = 0; hostFlowSetting = 0; hostIn.data = 8'h00; cfgIn = '0; userRdIdx = '0;
        step(3);
        nrst = 1;
        `CHK(serialPathMode, MODE_THROUGH)
        `CHK(logoutTens, 4'h2)
        `CHK({bypassRoute, remoteMgmtEn, passSet}, 3'b010)
        slow = 1;
        for (int i = 0; i < 40; i++) begin
            rnd = nxt(rnd);
            if (rnd[3]) step();
            host(rnd[15:8]);
        end
        step(20);
        `CHK(gotQ.size(), sentQ.size())
        foreach (sentQ[i]) `CHK(gotQ[i], sentQ[i])
        cfg(SEL_USER, "0123456789abcdefghijklmnopqrstuvwxyzABCDEFGHIJKLMNOPQRSTUVWXYZ+-");
        `CHK(userLen, 6'h3f)
        userRdIdx = 6'h3e;
        step();
        `CHK(userRdChar, 8'h2b)
        userRdIdx = 6'h3f;
        step();
        `CHK(userRdChar, 8'h00)
        cfg(SEL_PASS, "ab");
        cfg(SEL_VERIFY, "ax");
        `CHK({passSet, passErr}, 2'b01)
        cfg(SEL_PASS, "ab");
        cfg(SEL_VERIFY, "ab");
        `CHK({passSet, passErr}, 2'b10)
        // Control characters only, as operators are told to use
        cfg(SEL_ESC, "\001\002");
        cfg(SEL_ESC, "\033\033");
        cfg(SEL_LOGOUT, "1");
        `CHK(logoutTens, 4'h1)
        host(8'h01);
        host(8'h02);
        host(8'h1b);
        host(8'h01);
        host(8'h1b);
        step(3);
        `CHK(sessActive, 1'b0)
        host(8'h1b);
        step(3);
        `CHK({sessActive, sessRemote}, 2'b11)
        pulse_local();
        `CHK({sessActive, sessRemote}, 2'b11)
        modemRxActive = 1'b1;
        step();
        modemRxActive = 1'b0;
        n = 0;
        while (!hangupPulse && n < 200) begin
            step();
            n++;
        end
        `CHK(n inside {[97:103]}, 1'b1)
        step();
        `CHK(sessActive, 1'b0)
        cfg(SEL_LOGOUT, "0");
        cfg(SEL_LOGOUT, "a");
        `CHK(logoutTens, 4'h0)
        escape();
        n = 0;
        repeat (150) begin
            step();
            if (hangupPulse) n++;
        end
        `CHK({n == 0, sessActive}, 2'b11)
        quit();
        cfg(SEL_INIT, initStr);
        hostFlowSetting = rnd[0];
        enableRemote = 1'b1;
        step();
        enableRemote = 1'b0;
        expect_cmd(initStr, 31);
        `CHK({modemFlowCfg, modemCdEn}, {hostFlowSetting, 1'b1})
        cfg(SEL_DIAL, "atd9");
        cfg(SEL_ALERT, ",5#");
        alertIn = 1'b1;
        step();
        alertIn = 1'b0;
        expect_cmd("atd9,5#", 7);
        slow = 0;
        set_mode(MODE_SOFT);
        escape();
        `CHK({bypassRoute, sessActive}, 2'b10)
        lineUp = 1'b0;
        step(2);
        lineUp = 1'b1;
        `CHK(serialPathMode, MODE_SNOOP)
        escape();
        `CHK(sessActive, 1'b1)
        quit();
        set_mode(MODE_SOFT);
        hostPowerOn = 1'b0;
        step(2);
        hostPowerOn = 1'b1;
        `CHK(serialPathMode, MODE_SNOOP)
        set_mode(MODE_FIRM);
        escape();
        `CHK({bypassRoute, remoteMgmtEn, sessActive}, 3'b100)
        pulse_local();
        `CHK({sessActive, sessRemote}, 2'b10)
        complete_run();
    end
endmodule

// ---- verif/spcm_modem_model.sv ----
/*
 Modem model: accepts stream and command characters, stalling at random when slow.
 Assumes the bench drives lineUp to model carrier presence.
*/
`timescale 1ns/1ns
module spcm_modem_model
    import spcm_pkg::*;
(
    input wire logic core_clk,
    input wire logic slow,
    input wire logic lineUp,
    output logic modemReady,
    output logic modemCmdReady,
    output logic carrierDetect
);
    logic [7:0] stallReg = 8'h5a;
    // Stalls change just after the edge, like a real receiver
    always @(posedge core_clk) begin
        stallReg <= #1 {stallReg[6:0], stallReg[7] ^ stallReg[5] ^ stallReg[4] ^ stallReg[3]};
    end
    assign modemReady = !slow || stallReg[0];
    assign modemCmdReady = !slow || stallReg[1];
    assign carrierDetect = lineUp;
endmodule
